// *** common/socket_gc_pkg.sv ***
// Constants and types shared by the socket global control register block
package socket_gc_pkg;

   // Register byte offsets from the socket register base
   localparam logic [11:0] GLOBAL_CTRL_OFS      = 12'h81e;
   localparam logic [11:0] STATUS_CHANGE_OFS    = 12'h804;
   localparam logic [11:0] CARD_DETECT_CTRL_OFS = 12'h816;

   // Global control field positions
   localparam int CARD_B_LVL_BIT  = 4;
   localparam int CARD_A_LVL_BIT  = 3;
   localparam int FLAG_CLR_BIT    = 2;
   localparam int CSC_LVL_BIT     = 1;
   localparam int LOW_PWR_BIT     = 0;

   // Global control reset value and writable bits
   localparam logic [7:0] GLOBAL_CTRL_RST   = 8'h00;
   localparam logic [7:0] GLOBAL_CTRL_WMASK = 8'h1f;
   // Bits that any socket reset clears; the rest wait for the global reset
   localparam logic [7:0] SOCKET_RST_MASK   = 8'h18;

   // Status-change flags
   localparam int         STATUS_FLAG_W   = 4;
   localparam int         CD_CHANGE_BIT   = 3;
   localparam logic [3:0] STATUS_FLAG_RST = 4'h0;

   // Software card-detect request bit in the card detect control register
   localparam int SOFT_REQ_BIT = 5;

   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;

   // Power-down sequencing, one-hot
   typedef enum logic [2:0] {
      PD_OFF  = 3'b001,
      PD_HIZ  = 3'b010,
      PD_WAKE = 3'b100
   } pd_state_t;

endpackage : socket_gc_pkg

// *** common/status_change_if.sv ***
// Carrier between the global control register and the status-change flags
`timescale 1ns/1ps
`default_nettype none
interface status_change_if;
   import socket_gc_pkg::*;

   logic                     socket_reset;
   logic                     read_strobe;
   logic                     write_strobe;
   logic [7:0]               wdata;
   logic                     writeback_mode;
   logic                     soft_req_set;
   logic [STATUS_FLAG_W-1:0] events;
   logic [STATUS_FLAG_W-1:0] flags;
   logic                     soft_req;

   modport ctrl (
      output socket_reset,
      output read_strobe,
      output write_strobe,
      output wdata,
      output writeback_mode,
      output soft_req_set,
      output events,
      input  flags,
      input  soft_req
   );

   modport flag_blk (
      input  socket_reset,
      input  read_strobe,
      input  write_strobe,
      input  wdata,
      input  writeback_mode,
      input  soft_req_set,
      input  events,
      output flags,
      output soft_req
   );
endinterface : status_change_if
`default_nettype wire

// *** src/socket_global_control_reg.sv ***
// Socket global control register with interrupt signalling and power-down control
`timescale 1ns/1ps
`default_nettype none

//
// Behaviour
// - Bits 7 to 5 read zero, writes ignored
// - Bit 4: card B interrupt edge or level
// - Bit 3: card A interrupt edge or level
// - Bit 2 low: status read clears flags
// - Bit 2 high: flags clear by writing one
// - Bit 1: status-change interrupt edge or level
// - Bit 0: card outputs float until cycle
// - Card outputs float again after each cycle
// - Interrupts still taken; only access wakes
// - Bits 2 to 0 cleared by global reset only
// - Decoded at 81Eh, resets to zero
// - Write-one card-detect clear drops soft request
module socket_global_control_reg
   import socket_gc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     socket_reset,
   input  wire logic [11:0]              reg_addr,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [7:0]               reg_wdata,
   output logic      [7:0]               reg_rdata,
   output logic                          reg_rvalid,
   input  wire logic                     card_a_irq_pin,
   input  wire logic                     card_b_irq_pin,
   input  wire logic [STATUS_FLAG_W-1:0] status_events,
   input  wire logic                     cd_irq_enable,
   input  wire logic                     card_cycle_active,
   output logic                          host_irq_a,
   output logic                          host_irq_b,
   output logic                          host_irq_status,
   output logic                          card_out_en,
   output logic                          low_power_active
);

   localparam int NUM_PINS = 2;

   typedef struct packed {
      logic [7:0]                            ctrl;
      logic [NUM_PINS-1:0][SYNC_STAGES-1:0]  sync;
      logic [NUM_PINS-1:0]                   pin_level;
      logic [STATUS_FLAG_W-1:0]              flags_seen;
      pd_state_t                             pd;
      logic [7:0]                            rdata;
      logic                                  rvalid;
      logic                                  irq_a;
      logic                                  irq_b;
      logic                                  irq_status;
      logic                                  out_en;
      logic                                  low_power;
   } ctrl_state_t;

   ctrl_state_t s_q;
   ctrl_state_t s_d;

   status_change_if sc_if ();

   // Address match, used for every register in the map
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
      addr_hit = (addr == ofs);
   endfunction : addr_hit

   // A synchronised pin counts once its second and third stages agree
   function automatic logic stages_agree(input logic [SYNC_STAGES-1:0] chain);
      stages_agree = (chain[1] == chain[2]);
   endfunction : stages_agree

   // Host interrupt shaping: pulse on a new event, or follow the source
   function automatic logic irq_shape(input logic level_sel,
                                      input logic src_now,
                                      input logic src_new);
      irq_shape = level_sel ? src_now : src_new;
   endfunction : irq_shape

   logic hit_ctrl;
   logic hit_status;
   logic hit_cd_ctrl;

   assign hit_ctrl    = addr_hit(reg_addr, GLOBAL_CTRL_OFS);
   assign hit_status  = addr_hit(reg_addr, STATUS_CHANGE_OFS);
   assign hit_cd_ctrl = addr_hit(reg_addr, CARD_DETECT_CTRL_OFS);

   assign sc_if.socket_reset   = socket_reset;
   assign sc_if.read_strobe    = reg_rd && hit_status;
   assign sc_if.write_strobe   = reg_wr && hit_status;
   assign sc_if.wdata          = reg_wdata;
   assign sc_if.writeback_mode = s_q.ctrl[FLAG_CLR_BIT];
   assign sc_if.soft_req_set   = reg_wr && hit_cd_ctrl && reg_wdata[SOFT_REQ_BIT]
                                 && cd_irq_enable;
   assign sc_if.events         = status_events;

   status_change_flags u_flags (
      .clk    (clk),
      .arst_n (arst_n),
      .sc     (sc_if.flag_blk)
   );

   always_comb begin
      logic [NUM_PINS-1:0]      pin_rise;
      logic [STATUS_FLAG_W-1:0] new_flags;
      s_d       = s_q;
      pin_rise  = '0;
      new_flags = '0;

      // Register write; the top three bits are never stored
      if (reg_wr && hit_ctrl) begin
         s_d.ctrl = reg_wdata & GLOBAL_CTRL_WMASK;
      end
      // Socket reset touches only the interrupt mode bits of cards A and B
      if (socket_reset) begin
         s_d.ctrl = s_d.ctrl & ~SOCKET_RST_MASK;
      end

      // Read data, captured before any read-clear takes effect
      s_d.rvalid = reg_rd;
      s_d.rdata  = 8'h00;
      if (reg_rd) begin
         if (hit_ctrl) begin
            s_d.rdata = s_q.ctrl & GLOBAL_CTRL_WMASK;
         end else if (hit_status) begin
            s_d.rdata = {{(8 - STATUS_FLAG_W){1'b0}}, sc_if.flags};
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // Card interrupt pins pass a three-stage synchroniser
      for (int i = 0; i < NUM_PINS; i++) begin
         if (stages_agree(s_q.sync[i])) begin
            s_d.pin_level[i] = s_q.sync[i][2];
            pin_rise[i]      = s_q.sync[i][2] && !s_q.pin_level[i];
         end
      end
      s_d.sync[0] = {s_q.sync[0][SYNC_STAGES-2:0], card_a_irq_pin};
      s_d.sync[1] = {s_q.sync[1][SYNC_STAGES-2:0], card_b_irq_pin};

      // Functional interrupts keep arriving whatever the power state
      s_d.irq_a = irq_shape(s_q.ctrl[CARD_A_LVL_BIT], s_d.pin_level[0],
                            pin_rise[0]);
      s_d.irq_b = irq_shape(s_q.ctrl[CARD_B_LVL_BIT], s_d.pin_level[1],
                            pin_rise[1]);

      // Status-change interrupt from newly set flags
      new_flags        = sc_if.flags & ~s_q.flags_seen;
      s_d.flags_seen   = sc_if.flags;
      // A pending software card-detect request holds a level interrupt too
      s_d.irq_status   = irq_shape(s_q.ctrl[CSC_LVL_BIT],
                                   (|sc_if.flags) | sc_if.soft_req,
                                   |new_flags);

      // Power-down sequencing of the card outputs
      s_d.low_power = s_d.ctrl[LOW_PWR_BIT];
      case (s_q.pd)
         PD_OFF: begin
            if (s_q.ctrl[LOW_PWR_BIT]) begin
               s_d.pd = card_cycle_active ? PD_WAKE : PD_HIZ;
            end
         end
         PD_HIZ: begin
            if (!s_q.ctrl[LOW_PWR_BIT]) begin
               s_d.pd = PD_OFF;
            end else if (card_cycle_active) begin
               s_d.pd = PD_WAKE;
            end
         end
         PD_WAKE: begin
            if (!card_cycle_active) begin
               s_d.pd = s_q.ctrl[LOW_PWR_BIT] ? PD_HIZ : PD_OFF;
            end
         end
         default: begin
            s_d.pd = PD_OFF;
         end
      endcase
      s_d.out_en = (s_d.pd != PD_HIZ);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{ctrl:       GLOBAL_CTRL_RST,
                  sync:       '0,
                  pin_level:  '0,
                  flags_seen: STATUS_FLAG_RST,
                  pd:         PD_OFF,
                  rdata:      8'h00,
                  rvalid:     1'b0,
                  irq_a:      1'b0,
                  irq_b:      1'b0,
                  irq_status: 1'b0,
                  out_en:     1'b1,
                  low_power:  1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata        = s_q.rdata;
   assign reg_rvalid       = s_q.rvalid;
   assign host_irq_a       = s_q.irq_a;
   assign host_irq_b       = s_q.irq_b;
   assign host_irq_status  = s_q.irq_status;
   assign card_out_en      = s_q.out_en;
   assign low_power_active = s_q.low_power;

endmodule : socket_global_control_reg
`default_nettype wire

// *** src/status_change_flags.sv ***
// Card status-change flags with read-clear or write-one-clear behaviour
`timescale 1ns/1ps
`default_nettype none
module status_change_flags
   import socket_gc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          arst_n,
   status_change_if.flag_blk  sc
);

   typedef struct packed {
      logic [STATUS_FLAG_W-1:0] flags;
      logic                     soft_req;
   } flag_state_t;

   flag_state_t s_q;
   flag_state_t s_d;

   always_comb begin
      logic [STATUS_FLAG_W-1:0] clr;
      logic [STATUS_FLAG_W-1:0] set;
      clr = '0;
      set = sc.events;
      s_d = s_q;
      if (sc.read_strobe && !sc.writeback_mode) begin
         clr = '1;
      end
      if (sc.write_strobe && sc.writeback_mode) begin
         clr = sc.wdata[STATUS_FLAG_W-1:0];
      end
      if (sc.soft_req_set) begin
         set[CD_CHANGE_BIT] = 1'b1;
      end
      // A new event beats a clear in the same cycle
      s_d.flags = (s_q.flags & ~clr) | set;
      // The request never outlives the card-detect change flag it raised
      if (clr[CD_CHANGE_BIT]) begin
         s_d.soft_req = 1'b0;
      end
      if (sc.soft_req_set) begin
         s_d.soft_req = 1'b1;
      end
      if (sc.socket_reset) begin
         s_d.flags    = STATUS_FLAG_RST;
         s_d.soft_req = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{flags: STATUS_FLAG_RST, soft_req: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign sc.flags    = s_q.flags;
   assign sc.soft_req = s_q.soft_req;

endmodule : status_change_flags
`default_nettype wire

// *** verification/socket_gc_monitor.sv ***
// Port checker for the socket global control register
`timescale 1ns/1ps
`default_nettype none
module socket_gc_monitor
   import socket_gc_pkg::*;
(
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        socket_reset,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        card_a_irq_pin,
   input wire logic        card_cycle_active,
   input wire logic        host_irq_a,
   input wire logic        host_irq_b,
   input wire logic        host_irq_status,
   input wire logic        card_out_en,
   input wire logic        low_power_active
);
   // Expected mode bits, rebuilt from the writes seen
   logic [4:0] mode_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= 5'h00;
      end else begin
         if (reg_wr && reg_addr == GLOBAL_CTRL_OFS) begin
            mode_q <= reg_wdata[4:0];
         end
         // Socket reset wins over a same-cycle write for bits 4 and 3
         if (socket_reset) begin
            mode_q[4:3] <= 2'h0;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence ctrl_wr; reg_wr && reg_addr == GLOBAL_CTRL_OFS; endsequence
   sequence ctrl_rd; reg_rd && !reg_wr && reg_addr == GLOBAL_CTRL_OFS; endsequence
   read_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   ctrl_value_a: assert property (
      ctrl_rd |=> reg_rdata == {3'h0, $past(mode_q)})
      else $error("control read value wrong");
   unmapped_zero_a: assert property (reg_rd && reg_addr != GLOBAL_CTRL_OFS
      && reg_addr != STATUS_CHANGE_OFS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   low_power_a: assert property (
      ctrl_wr |=> low_power_active == mode_q[LOW_PWR_BIT])
      else $error("power-down bit not applied");
   float_idle_a: assert property (
      low_power_active && !card_cycle_active |=> !card_out_en)
      else $error("card outputs driven while idle");
   cycle_wake_a: assert property (card_cycle_active |=> card_out_en)
      else $error("card outputs not woken");
   awake_drive_a: assert property (!low_power_active [*2] |=> card_out_en)
      else $error("card outputs float outside power-down");
   edge_a_a: assert property (
      !mode_q[CARD_A_LVL_BIT] && host_irq_a |=> !host_irq_a)
      else $error("card A pulse too long");
   edge_b_a: assert property (
      !mode_q[CARD_B_LVL_BIT] && host_irq_b |=> !host_irq_b)
      else $error("card B pulse too long");
   edge_status_a: assert property (
      !mode_q[CSC_LVL_BIT] && host_irq_status |=> !host_irq_status)
      else $error("status pulse too long");
   level_a_a: assert property (
      (mode_q[CARD_A_LVL_BIT] && card_a_irq_pin) [*8] |-> host_irq_a)
      else $error("card A level not held");
endmodule : socket_gc_monitor
bind socket_global_control_reg socket_gc_monitor mon (.clk(clk), .arst_n(arst_n),
   .socket_reset(socket_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .card_a_irq_pin(card_a_irq_pin), .card_cycle_active(card_cycle_active),
   .host_irq_a(host_irq_a), .host_irq_b(host_irq_b), .host_irq_status(host_irq_status),
   .card_out_en(card_out_en), .low_power_active(low_power_active));
`default_nettype wire

// *** verification/socket_global_control_reg_test.sv ***
// Directed bench for the socket global control register
`timescale 1ns/1ps
`default_nettype none
module socket_global_control_reg_test;
   import socket_gc_pkg::*;
   logic        clk = 1'b0, arst_n = 1'b0, socket_reset = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        reg_rvalid, card_a_irq_pin = 1'b0, card_b_irq_pin = 1'b0;
   logic [3:0]  status_events = 4'h0;
   logic        cd_irq_enable = 1'b0, card_cycle_active = 1'b0;
   logic        host_irq_a, host_irq_b, host_irq_status, card_out_en, low_power_active;
   int          failures = 0, samples_checked = 0, cycles = 0, cnt;
   socket_global_control_reg uut (.clk(clk), .arst_n(arst_n), .socket_reset(socket_reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .card_a_irq_pin(card_a_irq_pin),
      .card_b_irq_pin(card_b_irq_pin), .status_events(status_events),
      .cd_irq_enable(cd_irq_enable), .card_cycle_active(card_cycle_active),
      .host_irq_a(host_irq_a), .host_irq_b(host_irq_b), .host_irq_status(host_irq_status),
      .card_out_en(card_out_en), .low_power_active(low_power_active));
   always #50 clk = ~clk;
   task automatic complete_run;
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         complete_run();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : write_reg
   task automatic read_chk(input logic [11:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      check({7'h00, reg_rvalid}, 8'h01);
      check(reg_rdata, exp);
      tick(1);
   endtask : read_chk
   function automatic logic irq_of(input int s);
      return (s == 0) ? host_irq_a : (s == 1) ? host_irq_b : host_irq_status;
   endfunction : irq_of
   task automatic set_pin(input int s, input logic v);
      if (s == 0) card_a_irq_pin = v;
      else card_b_irq_pin = v;
   endtask : set_pin
   // Counts cycles with the chosen host interrupt high
   task automatic count_irq(input int s, input int n);
      cnt = 0;
      repeat (n) begin
         tick(1);
         cnt += int'(irq_of(s) === 1'b1);
      end
   endtask : count_irq
   initial begin
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      read_chk(GLOBAL_CTRL_OFS, 8'h00);
      read_chk(12'h81f, 8'h00);
      read_chk(CARD_DETECT_CTRL_OFS, 8'h00);
      write_reg(GLOBAL_CTRL_OFS, 8'hff);
      read_chk(GLOBAL_CTRL_OFS, 8'h1f);
      check({7'h00, low_power_active}, 8'h01);
      tick(1);
      check({7'h00, card_out_en}, 8'h00);
      card_cycle_active = 1'b1;
      tick(1);
      check({7'h00, card_out_en}, 8'h01);
      tick(2);
      card_cycle_active = 1'b0;
      tick(1);
      check({7'h00, card_out_en}, 8'h00);
      socket_reset = 1'b1;
      tick(1);
      socket_reset = 1'b0;
      read_chk(GLOBAL_CTRL_OFS, 8'h07);
      arst_n = 1'b0;
      tick(1);
      arst_n = 1'b1;
      read_chk(GLOBAL_CTRL_OFS, 8'h00);
      // Read-clear flags, edge status interrupt, still taken in power-down
      write_reg(GLOBAL_CTRL_OFS, 8'h01);
      status_events = 4'h1;
      tick(1);
      status_events = 4'h0;
      count_irq(2, 6);
      check(cnt[7:0], 8'h01);
      read_chk(STATUS_CHANGE_OFS, 8'h01);
      read_chk(STATUS_CHANGE_OFS, 8'h00);
      // Write-one clear with level status interrupt
      write_reg(GLOBAL_CTRL_OFS, 8'h07);
      status_events = 4'h2;
      tick(1);
      status_events = 4'h0;
      tick(2);
      check({7'h00, host_irq_status}, 8'h01);
      read_chk(STATUS_CHANGE_OFS, 8'h02);
      read_chk(STATUS_CHANGE_OFS, 8'h02);
      check({7'h00, host_irq_status}, 8'h01);
      write_reg(STATUS_CHANGE_OFS, 8'h02);
      tick(2);
      check({7'h00, host_irq_status}, 8'h00);
      read_chk(STATUS_CHANGE_OFS, 8'h00);
      cd_irq_enable = 1'b1;
      write_reg(CARD_DETECT_CTRL_OFS, 8'h20);
      read_chk(STATUS_CHANGE_OFS, 8'h08);
      check({7'h00, host_irq_status}, 8'h01);
      write_reg(STATUS_CHANGE_OFS, 8'h08);
      read_chk(STATUS_CHANGE_OFS, 8'h00);
      check({7'h00, host_irq_status}, 8'h00);
      for (int s = 0; s < 2; s++) begin
         write_reg(GLOBAL_CTRL_OFS, 8'h01);
         set_pin(s, 1'b1);
         count_irq(s, 10);
         check(cnt[7:0], 8'h01);
         set_pin(s, 1'b0);
         tick(6);
         write_reg(GLOBAL_CTRL_OFS, (s == 0) ? 8'h09 : 8'h11);
         set_pin(s, 1'b1);
         count_irq(s, 12);
         check({7'h00, irq_of(s)}, 8'h01);
         set_pin(s, 1'b0);
         tick(6);
         check({7'h00, irq_of(s)}, 8'h00);
      end
      complete_run();
   end
endmodule : socket_global_control_reg_test
`default_nettype wire
